// file: dci_map.svh
`ifndef DCI_MAP_SVH
`define DCI_MAP_SVH
// Timing
`define DCI_CLK_NS 5
`define DCI_POR_NS 100000000
`define DCI_POR_CYC ((`DCI_POR_NS + `DCI_CLK_NS - 1) / `DCI_CLK_NS)
`define DCI_DEB_NS 2000000
`define DCI_DEB_CYC ((`DCI_DEB_NS + `DCI_CLK_NS - 1) / `DCI_CLK_NS)
`define DCI_POR_W 25
`define DCI_DEB_W 19
// Contact input bit positions
`define DCI_NIN 11
`define DCI_IN_FWD 0
`define DCI_IN_REV 1
`define DCI_IN_JOG 2
`define DCI_IN_RAMP 3
`define DCI_IN_INH 4
`define DCI_IN_CLR 5
`define DCI_IN_CUR 6
`define DCI_IN_RST 7
`define DCI_IN_MS 8
`define DCI_MS_W 3
// Mode select values
`define DCI_MODE_JOG 1'h0
`define DCI_MODE_THM 1'h1
// Field widths, limits, reset values
`define DCI_RAMP_W 12
`define DCI_RAMP_MAX 12'hE10
`define DCI_BOOST_W 8
`define DCI_VF_W 16
`define DCI_IREF_W 12
`define DCI_RAMP_RST 12'h000
`define DCI_BOOST_RST 8'h00
`define DCI_VF_RST 16'h0000
`define DCI_IREF_RST 12'h000
`endif

// file: dci_pkg.sv
package dci_pkg;
`include "dci_map.svh"
    typedef enum logic [2:0] {
        DCI_ST_INIT, DCI_ST_STOP, DCI_ST_RUN,
        DCI_ST_TRIP, DCI_ST_PLOSS, DCI_ST_HOLD
    } dci_state_e;
    typedef enum logic [1:0] {
        DCI_REF_VOLT, DCI_REF_CURR, DCI_REF_MULTI
    } dci_ref_e;
    typedef logic [`DCI_NIN-1:0] dci_in_t;
    typedef struct packed {
        dci_in_t clean;
        logic [`DCI_NIN-1:0][`DCI_DEB_W-1:0] cnt;
    } dci_deb_s;
    typedef struct packed {
        logic busy;
        logic [`DCI_POR_W-1:0] cnt;
    } dci_por_s;
    typedef struct packed {
        dci_state_e st;
        logic drive_en;
        logic run;
        logic rev;
        logic inch;
        logic fault;
        logic init;
        logic [`DCI_RAMP_W-1:0] accel;
        logic [`DCI_RAMP_W-1:0] decel;
        logic [`DCI_BOOST_W-1:0] boost;
        logic [`DCI_VF_W-1:0] vf;
        dci_ref_e rsel;
        logic [`DCI_IREF_W-1:0] iref;
    } dci_core_s;
endpackage

// file: dci_link_if.sv
`timescale 1ns/1ps
interface dci_link_if;
    import dci_pkg::*;
    dci_in_t clean;
    logic init_busy;
    modport deb (output clean);
    modport por (output init_busy);
    modport core (input clean, input init_busy);
endinterface

// file: dci_debounce.sv
`timescale 1ns/1ps
`include "dci_map.svh"
module dci_debounce #(
    parameter int unsigned CYC = `DCI_DEB_CYC
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Contacts
    input wire dci_pkg::dci_in_t raw_i,
    dci_link_if.deb link
);
    import dci_pkg::*;
    dci_deb_s q, next_q;
    dci_in_t hit;

    // A level must hold CYC cycles before it is believed
    always_comb begin
        next_q = q;
        for (int i = 0; i < `DCI_NIN; i++) begin
            hit[i] = (raw_i[i] != q.clean[i])
                && (q.cnt[i] == `DCI_DEB_W'(CYC - 1));
            if (raw_i[i] == q.clean[i]) begin
                next_q.cnt[i] = '0;
            end else if (hit[i]) begin
                next_q.clean[i] = raw_i[i]; // RULE_20
                next_q.cnt[i] = '0;
            end else begin
                next_q.cnt[i] = q.cnt[i] + `DCI_DEB_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    assign link.clean = q.clean;

    a_deb_stable: assert property ( // RULE_20
        @(posedge core_clk_i) disable iff (!rstn_i)
        (hit == '0) |=> $stable(q.clean))
        else $error("debounced level moved without a full count");
endmodule // dci_debounce

// file: dci_por.sv
`timescale 1ns/1ps
`include "dci_map.svh"
module dci_por #(
    parameter int unsigned CYC = `DCI_POR_CYC
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    dci_link_if.por link
);
    import dci_pkg::*;
    dci_por_s q, next_q;
    logic done;

    assign done = (q.cnt == `DCI_POR_W'(CYC - 1));

    always_comb begin
        next_q = q;
        if (q.busy) begin
            next_q.cnt = q.cnt + `DCI_POR_W'(1);
            next_q.busy = !done; // RULE_13
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            q <= '{busy: 1'b1, cnt: '0};
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    assign link.init_busy = q.busy;

    a_por_length: assert property ( // RULE_13
        @(posedge core_clk_i) disable iff (!rstn_i)
        q.busy && !done |=> q.busy)
        else $error("initial reset ended early");
endmodule // dci_por

// file: dci_ctrl_inputs.sv
`timescale 1ns/1ps
`include "dci_map.svh"
// Summary of operation
// [RULE_01] Mode 0: shared input selects jog
// [RULE_02] Mode 1: shared input is thermal contact
// [RULE_03] Thermal trip stops output, latches fault
// [RULE_04] Trip stays latched after contact recovers
// [RULE_05] Party clears trip by reset or power
// [RULE_06] Ramp select closed: second parameter set
// [RULE_07] Ramp select open: primary parameter set
// [RULE_08] Inhibit input coasts motor immediately
// [RULE_09] Party holds inhibit at least 20 ms
// [RULE_10] Fault clear cancels protective stop
// [RULE_11] Fault clear reinitialises, output off
// [RULE_12] Party holds fault clear 0.1 s
// [RULE_13] Power-up reset lasts 0.1 to 0.2 s
// [RULE_14] Output off during any reset
// [RULE_15] Current select closed: current reference used
// [RULE_16] Current select open: current reference ignored
// [RULE_17] Multi-step speed beats current reference
// [RULE_18] Restart select closed: auto restart
// [RULE_19] Restart select open: no auto restart
// [RULE_20] Debounce every contact before use
module dci_ctrl_inputs #(
    parameter int unsigned POR_CYC = `DCI_POR_CYC,
    parameter int unsigned DEB_CYC = `DCI_DEB_CYC
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Contact inputs, high = closed
    input wire logic forward_run_input_i,
    input wire logic reverse_run_input_i,
    input wire logic jog_or_thermal_input_i,
    input wire logic alt_ramp_select_i,
    input wire logic output_inhibit_i,
    input wire logic fault_clear_input_i,
    input wire logic current_ref_select_i,
    input wire logic restart_select_i,
    input wire logic [`DCI_MS_W-1:0] multi_speed_i,
    // Configuration
    input wire logic mode_select_i,
    input wire logic [`DCI_RAMP_W-1:0] accel1_i,
    input wire logic [`DCI_RAMP_W-1:0] decel1_i,
    input wire logic [`DCI_RAMP_W-1:0] accel2_i,
    input wire logic [`DCI_RAMP_W-1:0] decel2_i,
    input wire logic [`DCI_BOOST_W-1:0] boost1_i,
    input wire logic [`DCI_BOOST_W-1:0] boost2_i,
    input wire logic [`DCI_VF_W-1:0] vf1_i,
    input wire logic [`DCI_VF_W-1:0] vf2_i,
    // Supply and current loop
    input wire logic power_fail_i,
    input wire logic [`DCI_IREF_W-1:0] current_ref_i,
    // Drive control
    output logic drive_enable_o,
    output logic run_o,
    output logic reverse_o,
    output logic inch_mode_o,
    output logic fault_o,
    output logic ctrl_init_o,
    // Selected settings
    output logic [`DCI_RAMP_W-1:0] accel_time_o,
    output logic [`DCI_RAMP_W-1:0] decel_time_o,
    output logic [`DCI_BOOST_W-1:0] boost_o,
    output logic [`DCI_VF_W-1:0] vf_o,
    output dci_pkg::dci_ref_e ref_sel_o,
    output logic [`DCI_IREF_W-1:0] current_ref_o
);
    import dci_pkg::*;

    dci_link_if link ();
    dci_in_t raw;
    dci_core_s q, next_q;
    logic fwd, rev, start_any, jog_sel, thm, inh, init_hold;
    logic alt, cur_sel, rst_sel, ms_any;

    // Ramp times above the range saturate
    function automatic logic [`DCI_RAMP_W-1:0] clamp_ramp(
        input logic [`DCI_RAMP_W-1:0] t);
        return (t > `DCI_RAMP_MAX) ? `DCI_RAMP_MAX : t;
    endfunction

    assign raw = {multi_speed_i, restart_select_i,
        current_ref_select_i, fault_clear_input_i, output_inhibit_i,
        alt_ramp_select_i, jog_or_thermal_input_i,
        reverse_run_input_i, forward_run_input_i};

    dci_debounce #(.CYC(DEB_CYC)) u_deb (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .raw_i(raw),
        .link(link.deb)
    );

    dci_por #(.CYC(POR_CYC)) u_por (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .link(link.por)
    );

    assign fwd = link.clean[`DCI_IN_FWD];
    assign rev = link.clean[`DCI_IN_REV];
    // Both directions closed means stop
    assign start_any = fwd ^ rev;
    assign jog_sel = (mode_select_i == `DCI_MODE_JOG)
        && link.clean[`DCI_IN_JOG];
    assign thm = (mode_select_i == `DCI_MODE_THM)
        && link.clean[`DCI_IN_JOG];
    assign inh = link.clean[`DCI_IN_INH];
    assign alt = link.clean[`DCI_IN_RAMP];
    assign cur_sel = link.clean[`DCI_IN_CUR];
    assign rst_sel = link.clean[`DCI_IN_RST];
    assign ms_any = |link.clean[`DCI_IN_MS +: `DCI_MS_W];
    assign init_hold = link.init_busy
        || link.clean[`DCI_IN_CLR];

    always_comb begin
        next_q = q;
        if (init_hold) begin
            // Everything back to reset values
            next_q = '0; // RULE_10 RULE_11 RULE_14
            next_q.st = DCI_ST_INIT;
            next_q.init = 1'b1;
        end else begin
            unique case (q.st)
                // Contact still tripped after reset trips again
                DCI_ST_INIT: begin
                    if (thm) begin
                        next_q.st = DCI_ST_TRIP; // RULE_03
                    end else begin
                        next_q.st = DCI_ST_STOP; // RULE_10
                    end
                end
                DCI_ST_STOP: begin
                    if (thm) begin
                        next_q.st = DCI_ST_TRIP;
                    end else if (start_any && !power_fail_i) begin
                        next_q.st = DCI_ST_RUN;
                    end
                end
                DCI_ST_RUN: begin
                    if (thm) begin
                        next_q.st = DCI_ST_TRIP; // RULE_03
                    end else if (power_fail_i) begin
                        next_q.st = DCI_ST_PLOSS;
                    end else if (!start_any) begin
                        next_q.st = DCI_ST_STOP; // RULE_01
                    end
                end
                DCI_ST_PLOSS: begin
                    if (thm) begin
                        next_q.st = DCI_ST_TRIP;
                    end else if (!power_fail_i) begin
                        if (!rst_sel) begin
                            next_q.st = DCI_ST_HOLD; // RULE_19
                        end else if (start_any) begin
                            next_q.st = DCI_ST_RUN; // RULE_18
                        end else begin
                            next_q.st = DCI_ST_STOP;
                        end
                    end
                end
                // Start must be released before a new run
                DCI_ST_HOLD: begin
                    if (thm) begin
                        next_q.st = DCI_ST_TRIP;
                    end else if (!start_any) begin
                        next_q.st = DCI_ST_STOP;
                    end
                end
                // Only the reset path leaves a trip
                DCI_ST_TRIP: next_q.st = DCI_ST_TRIP; // RULE_04
                default: next_q.st = DCI_ST_INIT;
            endcase
            next_q.init = 1'b0;
            next_q.run = (next_q.st == DCI_ST_RUN);
            next_q.fault = (next_q.st == DCI_ST_TRIP);
            next_q.rev = next_q.run && rev;
            next_q.inch = next_q.run && jog_sel; // RULE_01 RULE_02
            // Inhibit gates output but keeps run state
            next_q.drive_en = next_q.run && !inh
                && !power_fail_i; // RULE_08
            if (alt) begin
                next_q.accel = clamp_ramp(accel2_i); // RULE_06
                next_q.decel = clamp_ramp(decel2_i);
                next_q.boost = boost2_i;
                next_q.vf = vf2_i;
            end else begin
                next_q.accel = clamp_ramp(accel1_i); // RULE_07
                next_q.decel = clamp_ramp(decel1_i);
                next_q.boost = boost1_i;
                next_q.vf = vf1_i;
            end
            if (ms_any) begin
                next_q.rsel = DCI_REF_MULTI; // RULE_17
                next_q.iref = `DCI_IREF_RST;
            end else if (cur_sel) begin
                next_q.rsel = DCI_REF_CURR; // RULE_15
                next_q.iref = current_ref_i;
            end else begin
                next_q.rsel = DCI_REF_VOLT; // RULE_16
                next_q.iref = `DCI_IREF_RST;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            q <= '{st: DCI_ST_INIT, init: 1'b1, rsel: DCI_REF_VOLT,
                accel: `DCI_RAMP_RST, decel: `DCI_RAMP_RST,
                boost: `DCI_BOOST_RST, vf: `DCI_VF_RST,
                iref: `DCI_IREF_RST, default: 1'b0};
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    assign drive_enable_o = q.drive_en;
    assign run_o = q.run;
    assign reverse_o = q.rev;
    assign inch_mode_o = q.inch;
    assign fault_o = q.fault;
    assign ctrl_init_o = q.init;
    assign accel_time_o = q.accel;
    assign decel_time_o = q.decel;
    assign boost_o = q.boost;
    assign vf_o = q.vf;
    assign ref_sel_o = q.rsel;
    assign current_ref_o = q.iref;

    a_jog_run: assert property ( // RULE_01
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && q.st == DCI_ST_RUN && start_any
        && jog_sel && !power_fail_i |=> run_o && inch_mode_o)
        else $error("jog select did not give jog run");
    a_jog_no_trip: assert property ( // RULE_02
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && !fault_o && jog_sel |=> !fault_o)
        else $error("jog select raised a fault");
    a_thermal_trip: assert property ( // RULE_03
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && thm |=> fault_o && !drive_enable_o)
        else $error("thermal contact did not trip");
    a_trip_latched: assert property ( // RULE_04
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && fault_o && !init_hold |=> fault_o && !run_o)
        else $error("trip released without reset");
    a_clear_init: assert property ( // RULE_11
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && link.clean[`DCI_IN_CLR]
        |=> ctrl_init_o && !fault_o && !drive_enable_o)
        else $error("fault clear did not reinitialise");
    a_init_off: assert property ( // RULE_14
        @(posedge core_clk_i) disable iff (!rstn_i)
        ctrl_init_o |-> !drive_enable_o && !run_o)
        else $error("output enabled during reset");
    a_inhibit_coast: assert property ( // RULE_08
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && inh |=> !drive_enable_o)
        else $error("inhibit did not cut output");
    a_ramp_alt: assert property ( // RULE_06
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && alt
        |=> vf_o == $past(vf2_i) && boost_o == $past(boost2_i))
        else $error("second set not selected");
    a_ramp_prim: assert property ( // RULE_07
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && !alt && accel1_i <= `DCI_RAMP_MAX
        |=> accel_time_o == $past(accel1_i))
        else $error("primary set not selected");
    a_iref_used: assert property ( // RULE_15
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && cur_sel && !ms_any
        |=> current_ref_o == $past(current_ref_i))
        else $error("current reference not passed");
    a_iref_ignored: assert property ( // RULE_16
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !cur_sel |=> current_ref_o == `DCI_IREF_RST)
        else $error("current reference leaked");
    a_multi_prio: assert property ( // RULE_17
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && ms_any |=> ref_sel_o == DCI_REF_MULTI)
        else $error("multi-step lost priority");
    a_restart_on: assert property ( // RULE_18
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && q.st == DCI_ST_PLOSS && !power_fail_i
        && rst_sel && start_any && !thm |=> run_o)
        else $error("no automatic restart");
    a_restart_off: assert property ( // RULE_19
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && q.st == DCI_ST_PLOSS && !rst_sel |=> !run_o)
        else $error("restart without select");
    a_clear_cancel: assert property ( // RULE_10
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && q.st == DCI_ST_INIT && !thm
        |=> !ctrl_init_o && !fault_o)
        else $error("control did not leave reset");
    a_supply_off: assert property ( // RULE_18
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && power_fail_i |=> !drive_enable_o)
        else $error("output on during supply loss");
    a_inhibit_keep: assert property ( // RULE_08
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && inh && q.st == DCI_ST_RUN && start_any
        && !thm && !power_fail_i |=> run_o && !drive_enable_o)
        else $error("inhibit disturbed run state");
    a_init_hold: assert property ( // RULE_14
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && init_hold
        |=> ctrl_init_o && !drive_enable_o && !run_o)
        else $error("output not held off in reset");
    a_por_init: assert property ( // RULE_13
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && link.init_busy |=> ctrl_init_o)
        else $error("power-up reset not shown");
    a_both_stop: assert property ( // RULE_01
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && fwd && rev |=> !run_o)
        else $error("both starts closed kept running");
    a_ramp_alt_time: assert property ( // RULE_06
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && alt && accel2_i <= `DCI_RAMP_MAX
        |=> accel_time_o == $past(accel2_i))
        else $error("second ramp time not selected");
    a_ramp_sat: assert property ( // RULE_06
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && alt && accel2_i > `DCI_RAMP_MAX
        |=> accel_time_o == `DCI_RAMP_MAX)
        else $error("ramp time not saturated");
    a_decel_prim: assert property ( // RULE_07
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && !alt && decel1_i <= `DCI_RAMP_MAX
        |=> decel_time_o == $past(decel1_i)
        && boost_o == $past(boost1_i))
        else $error("primary decel or boost not selected");
    a_hold_no_run: assert property ( // RULE_19
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && !init_hold && q.st == DCI_ST_HOLD |=> !run_o)
        else $error("run resumed from hold");
    a_thm_no_inch: assert property ( // RULE_02
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && mode_select_i == `DCI_MODE_THM |=> !inch_mode_o)
        else $error("jog run in thermal mode");
    a_multi_iref: assert property ( // RULE_17
        @(posedge core_clk_i) disable iff (!rstn_i)
        ce_i && ms_any |=> current_ref_o == `DCI_IREF_RST)
        else $error("current reference with multi-step");
endmodule // dci_ctrl_inputs

// file: dci_contact_model.sv
`timescale 1ns/1ps
`include "dci_map.svh"
module dci_contact_model #(
    parameter int unsigned HOLD = 4
) (
    // Clock
    input wire logic core_clk_i,
    // Wanted levels and bounce request, active while held high
    input wire dci_pkg::dci_in_t want_i,
    input wire logic bounce_i,
    // Contacts seen by the drive
    output dci_pkg::dci_in_t contact_o
);
    import dci_pkg::*;
    dci_in_t q = '0;
    dci_in_t nxt;
    int unsigned h_inh = 0;
    int unsigned h_clr = 0;
    // Short inhibit and fault-clear closures are stretched, never cut
    always @(posedge core_clk_i) begin
        nxt = want_i;
        if (q[`DCI_IN_INH] && h_inh != 0) nxt[`DCI_IN_INH] = 1'b1;
        if (q[`DCI_IN_CLR] && h_clr != 0) nxt[`DCI_IN_CLR] = 1'b1;
        if (nxt[`DCI_IN_INH] && !q[`DCI_IN_INH]) h_inh <= HOLD - 1;
        else if (h_inh != 0) h_inh <= h_inh - 1;
        if (nxt[`DCI_IN_CLR] && !q[`DCI_IN_CLR]) h_clr <= HOLD - 1;
        else if (h_clr != 0) h_clr <= h_clr - 1;
        q <= nxt;
    end
    // Bounce flips the forward contact for as long as it is held
    assign contact_o = q ^ (dci_in_t'(bounce_i) << `DCI_IN_FWD);
endmodule // dci_contact_model

// file: tb_top.sv
`timescale 1ns/1ps
`include "dci_map.svh"
module tb_top;
    import dci_pkg::*;
    localparam int unsigned POR = 20;
    localparam int unsigned DEB = 2;
    localparam int unsigned HOLD = 4;
    typedef struct packed {
        logic ramp;
        logic cur;
        logic [2:0] ms;
        dci_ref_e rs;
        logic iref_on;
    } dci_row_s;
    localparam dci_row_s ROWS [0:5] = '{
        '{1'b0, 1'b0, 3'h0, DCI_REF_VOLT, 1'b0},
        '{1'b1, 1'b0, 3'h0, DCI_REF_VOLT, 1'b0},
        '{1'b0, 1'b1, 3'h0, DCI_REF_CURR, 1'b1},
        '{1'b1, 1'b1, 3'h1, DCI_REF_MULTI, 1'b0},
        '{1'b0, 1'b1, 3'h4, DCI_REF_MULTI, 1'b0},
        '{1'b1, 1'b0, 3'h2, DCI_REF_MULTI, 1'b0}
    };
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic mode = 1'b0;
    logic pfail = 1'b0;
    logic bounce = 1'b0;
    logic ce = 1'b1;
    dci_in_t want = '0;
    dci_in_t ct;
    logic [11:0] a1 = '0, a2 = '0, d1 = '0, d2 = '0, cref = '0;
    logic [7:0] b1 = '0, b2 = '0;
    logic [15:0] v1 = '0, v2 = '0;
    logic drv, run, rev, inch, flt, init;
    logic [11:0] acc, dec, iref;
    logic [7:0] bst;
    logic [15:0] vf;
    dci_ref_e rs;
    int n_mismatch = 0;
    int n_checks = 0;
    int n;
    dci_row_s r;
    dci_contact_model #(.HOLD(HOLD)) partner (.core_clk_i(clk),
        .want_i(want), .bounce_i(bounce), .contact_o(ct));
    dci_ctrl_inputs #(.POR_CYC(POR), .DEB_CYC(DEB)) uut (
        .core_clk_i(clk), .rstn_i(rstn), .ce_i(ce),
        .forward_run_input_i(ct[`DCI_IN_FWD]),
        .reverse_run_input_i(ct[`DCI_IN_REV]),
        .jog_or_thermal_input_i(ct[`DCI_IN_JOG]),
        .alt_ramp_select_i(ct[`DCI_IN_RAMP]),
        .output_inhibit_i(ct[`DCI_IN_INH]),
        .fault_clear_input_i(ct[`DCI_IN_CLR]),
        .current_ref_select_i(ct[`DCI_IN_CUR]),
        .restart_select_i(ct[`DCI_IN_RST]),
        .multi_speed_i(ct[`DCI_IN_MS +: `DCI_MS_W]),
        .mode_select_i(mode), .accel1_i(a1), .decel1_i(d1),
        .accel2_i(a2), .decel2_i(d2), .boost1_i(b1), .boost2_i(b2),
        .vf1_i(v1), .vf2_i(v2), .power_fail_i(pfail),
        .current_ref_i(cref), .drive_enable_o(drv), .run_o(run),
        .reverse_o(rev), .inch_mode_o(inch), .fault_o(flt),
        .ctrl_init_o(init), .accel_time_o(acc), .decel_time_o(dec),
        .boost_o(bst), .vf_o(vf), .ref_sel_o(rs), .current_ref_o(iref));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic end_of_test();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic e, input logic g);
        chk(nm, 16'(e), 16'(g));
    endtask
    task automatic chk12(input string nm, input logic [11:0] e,
                         input logic [11:0] g);
        chk(nm, 16'(e), 16'(g));
    endtask
    // Inputs always move 1 ns after the edge
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // Model latency, stretch and debounce plus margin
    task automatic settle();
        step(DEB + HOLD + 4);
    endtask
    task automatic chk_run(input logic r, input logic d);
        chkb("run", r, run);
        chkb("drive", d, drv);
    endtask
    function automatic logic [11:0] sat(input logic [11:0] x);
        return (x > `DCI_RAMP_MAX) ? `DCI_RAMP_MAX : x;
    endfunction
    initial begin
        step(2);
        chkb("init_rst", 1'b1, init);
        chkb("drv_rst", 1'b0, drv);
        step(1);
        rstn = 1'b1;
        n = 0;
        while (init !== 1'b0 && n <= POR + 8) begin
            chkb("drv_por", 1'b0, drv);
            step(1);
            n++;
        end
        chkb("por_len", 1'b1, n >= POR && n <= POR + 3);
        for (int i = 0; i < 6; i++) begin
            r = ROWS[i];
            want[`DCI_IN_RAMP] = r.ramp;
            want[`DCI_IN_CUR] = r.cur;
            want[`DCI_IN_MS +: 3] = r.ms;
            a1 = 12'(16 * i + 3);
            d1 = a1 + 12'h001;
            a2 = 12'hE0F + 12'(i);
            d2 = a2 + 12'h001;
            b1 = 8'(i + 1);
            b2 = ~b1;
            v1 = 16'(257 * i + 5);
            v2 = ~v1;
            cref = 12'h5A5 ^ 12'(i);
            settle();
            chk12("accel", r.ramp ? sat(a2) : a1, acc);
            chk12("decel", r.ramp ? sat(d2) : d1, dec);
            chk("boost", 16'(r.ramp ? b2 : b1), 16'(bst));
            chk("vf", r.ramp ? v2 : v1, vf);
            chk("ref_sel", 16'(r.rs), 16'(rs));
            chk12("iref", r.iref_on ? cref : 12'h000, iref);
        end
        want = '0;
        want[`DCI_IN_FWD] = 1'b1;
        want[`DCI_IN_JOG] = 1'b1;
        settle();
        chk_run(1'b1, 1'b1);
        chkb("inch", 1'b1, inch);
        want[`DCI_IN_FWD] = 1'b0;
        settle();
        chk_run(1'b0, 1'b0);
        want = '0;
        want[`DCI_IN_REV] = 1'b1;
        settle();
        chkb("reverse", 1'b1, rev);
        want[`DCI_IN_FWD] = 1'b1;
        settle();
        chk_run(1'b0, 1'b0);
        want = '0;
        settle();
        // One-cycle chatter on a start contact
        bounce = 1'b1;
        step(1);
        bounce = 1'b0;
        settle();
        chk_run(1'b0, 1'b0);
        want[`DCI_IN_FWD] = 1'b1;
        settle();
        want[`DCI_IN_INH] = 1'b1;
        step(1);
        want[`DCI_IN_INH] = 1'b0;
        step(DEB + 4);
        chk_run(1'b1, 1'b0);
        settle();
        chk_run(1'b1, 1'b1);
        want[`DCI_IN_RST] = 1'b1;
        settle();
        for (int k = 0; k < 2; k++) begin
            pfail = 1'b1;
            step(3);
            chk_run(1'b0, 1'b0);
            pfail = 1'b0;
            step(3);
            chkb("restart", !k, run);
            want[`DCI_IN_RST] = 1'b0;
            settle();
        end
        mode = `DCI_MODE_THM;
        want[`DCI_IN_FWD] = 1'b0;
        settle();
        want[`DCI_IN_FWD] = 1'b1;
        settle();
        chk_run(1'b1, 1'b1);
        want[`DCI_IN_JOG] = 1'b1;
        settle();
        chk_run(1'b0, 1'b0);
        chkb("fault", 1'b1, flt);
        want[`DCI_IN_JOG] = 1'b0;
        settle();
        chk_run(1'b0, 1'b0);
        chkb("fault_held", 1'b1, flt);
        want[`DCI_IN_CLR] = 1'b1;
        settle();
        chkb("init_clr", 1'b1, init);
        chkb("fault_clr", 1'b0, flt);
        chk("accel_clr", 16'h0000, 16'(acc));
        chk_run(1'b0, 1'b0);
        want[`DCI_IN_CLR] = 1'b0;
        settle();
        chkb("init_end", 1'b0, init);
        chk_run(1'b1, 1'b1);
        // Enable low freezes filter and state; contacts still move
        ce = 1'b0;
        want[`DCI_IN_FWD] = 1'b0;
        settle();
        chk_run(1'b1, 1'b1);
        ce = 1'b1;
        settle();
        chk_run(1'b0, 1'b0);
        end_of_test();
    end
endmodule // tb_top
